// ==== verilog/iar_params.svh ====
`ifndef IAR_PARAMS_SVH
`define IAR_PARAMS_SVH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define IAR_NUM_CH 4
`define IAR_NUM_SRC 48
`define IAR_SRC_W 6
`define IAR_ADDR_W 8
`define IAR_ACTEN_REGS 6
`define IAR_ACTEN_BITS 8

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define IAR_OFS_SRCSEL 8'h00
`define IAR_OFS_MODE 8'h10
`define IAR_OFS_ACTEN 8'h20
`define IAR_OFS_ACTEN_G 8'h38
`define IAR_OFS_ACTEN_H 8'h3C
`define IAR_OFS_STAT_LO 8'h40
`define IAR_OFS_STAT_HI 8'h44
`define IAR_OFS_CLR_LO 8'h48
`define IAR_OFS_CLR_HI 8'h4C
`define IAR_OFS_EN_LO 8'h50
`define IAR_OFS_EN_HI 8'h54
`define IAR_OFS_FLAG_LO 8'h58
`define IAR_OFS_FLAG_HI 8'h5C

// ----------------------------------------------------------------
// Reset values and responses
// ----------------------------------------------------------------
`define IAR_RST_SEL 6'h00
`define IAR_RST_MODE 4'h0
`define IAR_RST_VEC 48'h0000_0000_0000
`define IAR_RESP_OKAY 2'h0
`define IAR_RESP_SLVERR 2'h2

`endif

// ==== verilog/iar_pkg.sv ====
`default_nettype none
`include "iar_params.svh"

package iar_pkg;

    // Channel mode field layout, bit 3 down to bit 0
    typedef struct packed {
        logic trigger_kind_high;
        logic trigger_kind_low;
        logic channel_transfer_enable;
        logic source_ownership_bit;
    } iar_mode_s;

    // One register write, handed from the bus slave to the core
    typedef struct packed {
        logic en;
        logic [`IAR_ADDR_W-1:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } iar_wr_s;

    // Where a pending source request currently goes
    typedef enum logic [1:0] {
        ROUTE_DMA,
        ROUTE_XFER,
        ROUTE_CPU
    } iar_route_e;

endpackage
`default_nettype wire

// ==== verilog/iar_axil_slave.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "iar_params.svh"

module iar_axil_slave (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [`IAR_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [`IAR_ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output iar_pkg::iar_wr_s wr,
    input wire logic wr_err,
    output logic [`IAR_ADDR_W-1:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_err
);
    logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
    logic [`IAR_ADDR_W-1:0] awaddr_reg, awaddr_next;
    logic [31:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic fire, rd_take;

    // Address and data may arrive in either order; each is held alone
    assign s_axi_awready = ~aw_held_reg;
    assign s_axi_wready = ~w_held_reg;
    assign fire = aw_held_reg & w_held_reg & ~bvalid_reg;
    assign wr = '{en: fire, addr: awaddr_reg, data: wdata_reg,
                  strb: wstrb_reg};
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    // One read in flight; the next is refused until the data is taken
    assign s_axi_arready = ~rvalid_reg;
    assign rd_take = s_axi_arvalid & ~rvalid_reg;
    assign rd_addr = s_axi_araddr;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // Channel bookkeeping
    always_comb begin
        aw_held_next = aw_held_reg;
        awaddr_next = awaddr_reg;
        w_held_next = w_held_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (s_axi_awvalid && !aw_held_reg) begin
            aw_held_next = 1'b1;
            awaddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held_reg) begin
            w_held_next = 1'b1;
            wdata_next = s_axi_wdata;
            wstrb_next = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (fire) begin
            aw_held_next = 1'b0;
            w_held_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = wr_err ? `IAR_RESP_SLVERR : `IAR_RESP_OKAY;
        end
        if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        if (rd_take) begin
            rvalid_next = 1'b1;
            rdata_next = rd_data;
            rresp_next = rd_err ? `IAR_RESP_SLVERR : `IAR_RESP_OKAY;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            awaddr_reg <= '0;
            w_held_reg <= 1'b0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `IAR_RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= `IAR_RESP_OKAY;
        end else begin
            aw_held_reg <= aw_held_next;
            awaddr_reg <= awaddr_next;
            w_held_reg <= w_held_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end
endmodule
`default_nettype wire

// ==== verilog/iar_dma_select.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "iar_params.svh"

module iar_dma_select #(
    parameter int NUM_CH = `IAR_NUM_CH,
    parameter int NUM_SRC = `IAR_NUM_SRC,
    parameter int SRC_W = `IAR_SRC_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [NUM_SRC-1:0] flags,
    input wire logic [NUM_CH-1:0][SRC_W-1:0] sel,
    input wire iar_pkg::iar_mode_s [NUM_CH-1:0] mode,
    input wire logic [NUM_CH-1:0] dma_ack,
    output logic [NUM_CH-1:0] dma_req_reg,
    output logic [NUM_SRC-1:0] owned,
    output logic [NUM_SRC-1:0] ack_clr
);
    logic [NUM_CH-1:0] own_en, dma_req_next;

    // Per-channel select path, kept apart from the other two paths
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        // Module-interrupt trigger, enabled and claimed by the channel
        assign own_en[c] = mode[c].trigger_kind_high &
                           ~mode[c].trigger_kind_low &
                           mode[c].channel_transfer_enable &
                           mode[c].source_ownership_bit; // RULE3
        // Out-of-range selects pick nothing rather than wrapping
        assign dma_req_next[c] = (int'(sel[c]) < NUM_SRC) ?
                                 flags[sel[c]] : 1'b0; // RULE1 RULE2

        AST_DMA_PICK: assert property ( // RULE1
            @(posedge aclk) disable iff (!aresetn)
            (int'(sel[c]) < NUM_SRC) && flags[sel[c]]
            |=> dma_req_reg[c])
            else $error("selected request not passed to channel");
    end

    // Ownership map and acknowledge-driven clears, per source
    always_comb begin
        owned = '0;
        ack_clr = '0;
        for (int c = 0; c < NUM_CH; c++) begin
            if (own_en[c] && int'(sel[c]) < NUM_SRC) begin
                owned[sel[c]] = 1'b1;
                ack_clr[sel[c]] = ack_clr[sel[c]] | dma_ack[c];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dma_req_reg <= '0;
        end else begin
            dma_req_reg <= dma_req_next;
        end
    end
endmodule
`default_nettype wire

// ==== verilog/iar_router.sv ====
// Contract
// RULE1: Each DMA channel picks its request from the sources by its select.
// RULE2: The picked request reaches the DMA through its own select path.
// RULE3: Enabled module-trigger channel with ownership takes the source alone.
// RULE4: Unowned sources go to the transfer controller or to the CPU.
// RULE5: Activation enables live in six registers A-F; G and H absent.
// RULE6: Flag clearing depends on ownership, activation enable and transfer select.
// RULE7: Enable bit set routes to transfer controller, clear routes to CPU.
//
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "iar_params.svh"

module iar_router #(
    parameter int NUM_CH = `IAR_NUM_CH,
    parameter int NUM_SRC = `IAR_NUM_SRC,
    parameter int SRC_W = `IAR_SRC_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [`IAR_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [`IAR_ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic [NUM_SRC-1:0] src_req,
    output logic [NUM_CH-1:0] dma_req,
    input wire logic [NUM_CH-1:0] dma_ack,
    output logic [NUM_SRC-1:0] xfer_act,
    input wire logic xfer_done,
    input wire logic [SRC_W-1:0] xfer_done_src,
    input wire logic per_transfer_irq_select,
    output logic cpu_irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    localparam logic [`IAR_ADDR_W-1:0] ONE_WORD = 8'h04;

    function automatic logic reg_hit(input logic [`IAR_ADDR_W-1:0] a,
                                     input logic [`IAR_ADDR_W-1:0] base,
                                     input int idx);
        reg_hit = (a == base + 8'(idx * 4));
    endfunction

    // G and H slots stay holes in the map
    function automatic logic is_mapped(input logic [`IAR_ADDR_W-1:0] a);
        is_mapped = (a[1:0] == 2'h0) && (a <= `IAR_OFS_FLAG_HI) &&
                    (a != `IAR_OFS_ACTEN_G) && (a != `IAR_OFS_ACTEN_H);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] strb);
        for (int b = 0; b < 4; b++) begin
            old[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
        end
        merge = old;
    endfunction

    function automatic iar_pkg::iar_route_e route_of(input logic own,
                                                     input logic act);
        if (own) begin
            route_of = iar_pkg::ROUTE_DMA;
        end else if (act) begin
            route_of = iar_pkg::ROUTE_XFER;
        end else begin
            route_of = iar_pkg::ROUTE_CPU;
        end
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    iar_pkg::iar_wr_s wr;
    logic wr_err, rd_err;
    logic [`IAR_ADDR_W-1:0] rd_addr;
    logic [31:0] rd_data;
    logic [NUM_CH-1:0][SRC_W-1:0] sel_reg, sel_next;
    iar_pkg::iar_mode_s [NUM_CH-1:0] mode_reg, mode_next;
    logic [NUM_SRC-1:0] acten_reg, acten_next, en_reg, en_next;
    logic [NUM_SRC-1:0] stat_reg, stat_next, flag_reg, flag_next;
    logic [NUM_SRC-1:0] xfer_act_reg, xfer_act_next, clr_vec;
    logic [NUM_SRC-1:0] owned, ack_clr, routed;
    logic [31:0] en_hi32, clr_w;

    iar_axil_slave u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .wr(wr),
        .wr_err(wr_err),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    iar_dma_select #(
        .NUM_CH(NUM_CH),
        .NUM_SRC(NUM_SRC),
        .SRC_W(SRC_W)
    ) u_sel (
        .aclk(aclk),
        .aresetn(aresetn),
        .flags(flag_reg),
        .sel(sel_reg),
        .mode(mode_reg),
        .dma_ack(dma_ack),
        .dma_req_reg(dma_req),
        .owned(owned),
        .ack_clr(ack_clr)
    );

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    // Byte lane 0 carries every narrow field
    always_comb begin
        sel_next = sel_reg;
        mode_next = mode_reg;
        acten_next = acten_reg;
        en_next = en_reg;
        clr_vec = '0;
        en_hi32 = merge(32'(en_reg[NUM_SRC-1:32]), wr.data, wr.strb);
        clr_w = merge(32'h0000_0000, wr.data, wr.strb);
        wr_err = wr.en && !is_mapped(wr.addr); // RULE5
        if (wr.en && wr.strb[0]) begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (reg_hit(wr.addr, `IAR_OFS_SRCSEL, c)) begin
                    sel_next[c] = wr.data[SRC_W-1:0];
                end
                if (reg_hit(wr.addr, `IAR_OFS_MODE, c)) begin
                    mode_next[c] = wr.data[3:0];
                end
            end
            // Only A-F exist; G and H fall out of this loop
            for (int k = 0; k < `IAR_ACTEN_REGS; k++) begin
                if (reg_hit(wr.addr, `IAR_OFS_ACTEN, k)) begin
                    acten_next[k*8 +: 8] = wr.data[7:0]; // RULE5
                end
            end
        end
        if (wr.en) begin
            if (wr.addr == `IAR_OFS_EN_LO) begin
                en_next[31:0] = merge(en_reg[31:0], wr.data, wr.strb);
            end
            if (wr.addr == `IAR_OFS_EN_HI) begin
                en_next[NUM_SRC-1:32] = en_hi32[NUM_SRC-33:0];
            end
            if (wr.addr == `IAR_OFS_CLR_LO) begin
                clr_vec[31:0] = clr_w;
            end
            if (wr.addr == `IAR_OFS_CLR_HI) begin
                clr_vec[NUM_SRC-1:32] = clr_w[NUM_SRC-33:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------
    // Clear register is write-only and reads zero
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_err = !is_mapped(rd_addr); // RULE5
        for (int c = 0; c < NUM_CH; c++) begin
            if (reg_hit(rd_addr, `IAR_OFS_SRCSEL, c)) begin
                rd_data = 32'(sel_reg[c]);
            end
            if (reg_hit(rd_addr, `IAR_OFS_MODE, c)) begin
                rd_data = 32'(mode_reg[c]);
            end
        end
        for (int k = 0; k < `IAR_ACTEN_REGS; k++) begin
            if (reg_hit(rd_addr, `IAR_OFS_ACTEN, k)) begin
                rd_data = 32'(acten_reg[k*8 +: 8]);
            end
        end
        case (rd_addr)
            `IAR_OFS_STAT_LO: rd_data = stat_reg[31:0];
            `IAR_OFS_STAT_HI: rd_data = 32'(stat_reg[NUM_SRC-1:32]);
            `IAR_OFS_EN_LO: rd_data = en_reg[31:0];
            `IAR_OFS_EN_HI: rd_data = 32'(en_reg[NUM_SRC-1:32]);
            `IAR_OFS_FLAG_LO: rd_data = flag_reg[31:0];
            `IAR_OFS_FLAG_HI: rd_data = 32'(flag_reg[NUM_SRC-1:32]);
            default: ;
        endcase
    end

    // ------------------------------------------------------------
    // Source flags, routing and clear control
    // ------------------------------------------------------------
    // A fresh request always beats any clear in the same cycle
    always_comb begin
        logic hit;
        logic xclr;
        iar_pkg::iar_route_e rt;
        hit = 1'b0;
        xclr = 1'b0;
        rt = iar_pkg::ROUTE_CPU;
        for (int i = 0; i < NUM_SRC; i++) begin
            hit = xfer_done && (int'(xfer_done_src) == i);
            rt = route_of(owned[i], acten_reg[i]); // RULE4 RULE7
            xclr = 1'b0;
            stat_next[i] = stat_reg[i] & ~clr_vec[i];
            xfer_act_next[i] = 1'b0;
            case (rt)
                iar_pkg::ROUTE_DMA: begin
                    xclr = ack_clr[i]; // RULE3 RULE6
                end
                iar_pkg::ROUTE_XFER: begin
                    // Select set: flag kept, CPU asked after the transfer
                    xclr = hit & ~per_transfer_irq_select; // RULE6
                    if (flag_reg[i] && hit && per_transfer_irq_select) begin
                        stat_next[i] = 1'b1; // RULE6
                    end
                    xfer_act_next[i] = flag_reg[i] & ~stat_reg[i] &
                                       ~(xclr & ~src_req[i]); // RULE7
                end
                iar_pkg::ROUTE_CPU: begin
                    if (flag_reg[i] && !clr_vec[i]) begin
                        stat_next[i] = 1'b1; // RULE7
                    end
                end
                default: ;
            endcase
            flag_next[i] = src_req[i] |
                           (flag_reg[i] & ~(xclr | clr_vec[i])); // RULE6
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_reg <= {NUM_CH{`IAR_RST_SEL}};
            mode_reg <= {NUM_CH{`IAR_RST_MODE}};
            acten_reg <= `IAR_RST_VEC;
            en_reg <= `IAR_RST_VEC;
            stat_reg <= `IAR_RST_VEC;
            flag_reg <= `IAR_RST_VEC;
            xfer_act_reg <= `IAR_RST_VEC;
        end else begin
            sel_reg <= sel_next;
            mode_reg <= mode_next;
            acten_reg <= acten_next;
            en_reg <= en_next;
            stat_reg <= stat_next;
            flag_reg <= flag_next;
            xfer_act_reg <= xfer_act_next;
        end
    end

    // Level interrupt; no extra latency beyond the status flop
    assign xfer_act = xfer_act_reg;
    assign cpu_irq = |(stat_reg & en_reg);
    assign routed = flag_reg & ~owned;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_done_keep;
        xfer_done && per_transfer_irq_select && flag_reg[xfer_done_src] &&
        !owned[xfer_done_src] && acten_reg[xfer_done_src];
    endsequence

    sequence s_done_drop;
        xfer_done && !per_transfer_irq_select && !src_req[xfer_done_src] &&
        !owned[xfer_done_src] && acten_reg[xfer_done_src];
    endsequence

    AST_OWN_EXCL: assert property ( // RULE3
        1'b1 |=> ((xfer_act_reg & $past(owned)) == '0))
        else $error("owned source reached transfer controller");
    AST_OWN_NO_CPU: assert property ( // RULE3
        1'b1 |=> (($past(owned & ~stat_reg) & stat_reg) == '0))
        else $error("owned source raised CPU status");
    AST_ROUTE: assert property ( // RULE4
        1'b1 |=> (($past(routed & ~clr_vec) & flag_reg &
                   ~(xfer_act_reg | stat_reg)) == '0))
        else $error("unowned pending source went nowhere");
    AST_GH_ABSENT: assert property ( // RULE5
        wr.en && (wr.addr == `IAR_OFS_ACTEN_G ||
                  wr.addr == `IAR_OFS_ACTEN_H)
        |-> wr_err && acten_next == acten_reg)
        else $error("write to absent enable register accepted");
    AST_CLR_KEEP: assert property ( // RULE6
        s_done_keep |=> flag_reg[$past(xfer_done_src)] &&
                        stat_reg[$past(xfer_done_src)] ##1
                        !xfer_act_reg[$past(xfer_done_src, 2)])
        else $error("flag lost or CPU not asked after transfer");
    AST_CLR_DROP: assert property ( // RULE6
        s_done_drop |=> !flag_reg[$past(xfer_done_src)])
        else $error("flag not cleared after transfer");
    AST_CPU_PATH: assert property ( // RULE7
        1'b1 |=> (($past(routed & ~acten_reg & ~clr_vec) &
                   ~stat_reg) == '0))
        else $error("disabled source did not reach CPU status");
endmodule
`default_nettype wire

// ==== bench/iar_far_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// DMA channels and transfer controller as the router sees them
// ------------------------------------------------------------
module iar_far_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic stall,
    input wire logic isel,
    input wire logic [3:0] dma_req,
    output logic [3:0] dma_ack,
    input wire logic [47:0] xfer_act,
    output logic xfer_done,
    output logic [5:0] xfer_done_src,
    output logic per_transfer_irq_select
);
    logic [1:0] busy;
    // Stall holds off both answers; busy covers the two-cycle drop lag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dma_ack <= 4'h0;
            xfer_done <= 1'b0;
            busy <= 2'h0;
            xfer_done_src <= 6'h00;
        end else begin
            dma_ack <= stall ? 4'h0 : dma_req & ~dma_ack;
            busy <= {busy[0], xfer_done};
            xfer_done <= 1'b0;
            xfer_done_src <= ~xfer_done_src; // Idle source is junk
            if (!stall && busy == 2'h0 && !xfer_done && xfer_act != '0) begin
                xfer_done <= 1'b1;
                for (int i = 47; i >= 0; i--) begin
                    if (xfer_act[i]) xfer_done_src <= 6'(i);
                end
            end
        end
    end
    // Select is only meaningful alongside the done pulse
    assign per_transfer_irq_select = xfer_done ? isel : ~isel;
endmodule
`default_nettype wire

// ==== bench/tb_interrupt_activation_router.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_interrupt_activation_router;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
    logic awr, wrd, bv, arr, rv, xdone, xsel, irq;
    logic isel = 1'b0, stall = 1'b0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0000_0000, rd;
    logic [1:0] br, rr;
    logic [47:0] src = '0, xact;
    logic [3:0] dreq, dack;
    logic [5:0] xsrc;
    logic [3:0] modes [5] = '{4'hB, 4'hA, 4'h9, 4'hF, 4'h3};
    int err_total = 0, checked = 0, dcnt = 0;
    // ------------------------------------------------------------
    // Clock, instances, watchdog
    // ------------------------------------------------------------
    initial begin
        forever #10 aclk = ~aclk;
    end
    always @(posedge aclk) dcnt <= dcnt + int'(dreq[0]);
    iar_router i_iar_router (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
        .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(bre),
        .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rre),
        .s_axi_rdata(rd), .s_axi_rresp(rr), .src_req(src),
        .dma_req(dreq), .dma_ack(dack), .xfer_act(xact),
        .xfer_done(xdone), .xfer_done_src(xsrc),
        .per_transfer_irq_select(xsel), .cpu_irq(irq));
    iar_far_model i_iar_far_model (.aclk(aclk), .aresetn(aresetn),
        .stall(stall), .isel(isel), .dma_req(dreq), .dma_ack(dack),
        .xfer_act(xact), .xfer_done(xdone), .xfer_done_src(xsrc),
        .per_transfer_irq_select(xsel));
    initial begin
        repeat (20000) @(posedge aclk);
        err_total++;
        give_verdict();
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("errors %0d checks %0d", err_total, checked);
        if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Write both channels at once; response checked on bvalid edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] e);
        @(posedge aclk);
        {awv, wv, bre} <= 3'b111;
        awa <= a;
        wd <= d;
        do begin
            @(posedge aclk);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
        end while (!bv);
        bre <= 1'b0;
        chk({30'h0, br}, {30'h0, e});
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                       input logic [1:0] er);
        @(posedge aclk);
        {arv, rre} <= 2'b11;
        ara <= a;
        do begin
            @(posedge aclk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        rre <= 1'b0;
        chk(rd, e);
        chk({30'h0, rr}, {30'h0, er});
    endtask
    task automatic fire(input int s);
        @(posedge aclk);
        src[s] <= 1'b1;
        @(posedge aclk);
        src[s] <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        rdc(8'h38, 32'h0, 2'h2);
        rdc(8'h3C, 32'h0, 2'h2);
        wr(8'h3C, 32'hFF, 2'h2);
        wr(8'h34, 32'hA5, 2'h0);
        rdc(8'h34, 32'hA5, 2'h0);
        wr(8'h34, 32'h0, 2'h0);
    endtask
    // Only the exact module-trigger, enabled, owned mode keeps the CPU out
    task automatic t_own();
        int d0;
        logic own;
        wr(8'h00, 32'h5, 2'h0);
        wr(8'h50, 32'hFFFF_FFFF, 2'h0);
        foreach (modes[m]) begin
            own = (modes[m] == 4'hB);
            wr(8'h10, {28'h0, modes[m]}, 2'h0);
            d0 = dcnt;
            fire(5);
            chk(32'(dcnt > d0), 32'h1);
            chk({31'h0, xact[5]}, 32'h0);
            rdc(8'h40, own ? 32'h0 : 32'h20, 2'h0);
            rdc(8'h58, own ? 32'h0 : 32'h20, 2'h0);
            chk({31'h0, irq}, {31'h0, !own});
            wr(8'h48, 32'h20, 2'h0);
            chk({31'h0, irq}, 32'h0);
        end
        wr(8'h10, 32'h0, 2'h0);
    endtask
    // Enabled source goes to the transfer controller; select picks clear
    task automatic t_xfer();
        wr(8'h24, 32'h02, 2'h0);
        fire(9);
        rdc(8'h58, 32'h0, 2'h0);
        rdc(8'h40, 32'h0, 2'h0);
        isel <= 1'b1;
        stall <= 1'b1;
        fire(9);
        chk({31'h0, xact[9]}, 32'h1);
        chk({31'h0, irq}, 32'h0);
        stall <= 1'b0;
        repeat (5) @(posedge aclk);
        chk({31'h0, xact[9]}, 32'h0);
        rdc(8'h40, 32'h200, 2'h0);
        chk({31'h0, irq}, 32'h1);
        wr(8'h50, 32'h0, 2'h0);
        chk({31'h0, irq}, 32'h0);
        wr(8'h4C, 32'h0, 2'h0);
        wr(8'h48, 32'h200, 2'h0);
        rdc(8'h40, 32'h0, 2'h0);
    endtask
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        chk({27'h0, irq, dreq}, 32'h0);
        t_regs();
        t_own();
        t_xfer();
        give_verdict();
    end
endmodule
`default_nettype wire
